// *** hpp_pkg.sv ***
// package for the host parallel port handshake block
`default_nettype none
package hpp_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  // reference clock period in ns, figure as printed for timing maths
  localparam int CLK_PERIOD_NS = 10;
  // ack reaction limit, ns, longest time rounds down
  localparam int ACK_MAX_NS = 12;
  localparam int ACK_MAX_CYC = (ACK_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 :
                               (ACK_MAX_NS / CLK_PERIOD_NS);
  // release limit after access end, ns
  localparam int REL_MAX_NS = 5;
  // sample point: two reference periods after access start
  localparam int SAMPLE_PERIODS = 2;
  // read drive start: three reference periods after access start
  localparam int DRIVE_PERIODS = 3;
  // data valid ahead of ack edge: one reference period
  localparam int LEAD_PERIODS = 1;
  localparam int CNT_W = 4;
  localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
  localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
  localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

  typedef enum logic {
    HPP_MODE_SEP = 1'b0,
    HPP_MODE_DS = 1'b1
  } hpp_mode_t;

  // host pin bundle, all active low strobes
  typedef struct packed {
    logic sel_n;
    logic write_or_data_strobe_n;
    logic rd_or_dir_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hpp_pins_t;

  // internal register access request
  typedef struct packed {
    logic write;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } hpp_req_t;
endpackage : hpp_pkg
`default_nettype wire

// *** hpp_port.sv ***
// host parallel port: strobe decode, handshake and data bus control
// Behaviour
// - separate mode: access while select AND a strobe low
// - separate mode: ack low quickly, high when done
// - separate mode: float ack after access ends
// - read drive starts three periods after start
// - separate mode: data valid period before ack rise
// - strobe mode: data valid period before ack fall
// - read drive stops soon after access ends
// - strobe mode: drive ack high, later low
// - strobe mode: ack high then float after end
`default_nettype none
module hpp_port (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire hpp_pkg::hpp_mode_t mode_in,
  input wire hpp_pkg::hpp_pins_t pins_in,
  output logic ack_n_out,
  output logic ack_oe_out,
  output logic [hpp_pkg::DATA_W-1:0] data_out,
  output logic data_oe_out,
  output hpp_pkg::hpp_req_t req_out,
  output logic req_valid_out,
  input wire logic done_in,
  input wire logic [hpp_pkg::DATA_W-1:0] rdata_in
);
  import hpp_pkg::*;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  // the whole bundle passes two stages; addr and data settle long
  // before the sample point, so the added latency costs nothing
  // and the state machine never sees a pin that is mid-settle
  hpp_pins_t s1_ff, s2_ff, nxt_s1, nxt_s2;
  always_comb begin
    nxt_s1 = pins_in;
    nxt_s2 = s1_ff;
  end
  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      s1_ff <= '1;
      s2_ff <= '1;
    end else begin
      s1_ff <= nxt_s1;
      s2_ff <= nxt_s2;
    end
  end

  logic sel_n_s, wds_n_s, rdd_n_s;
  assign sel_n_s = s2_ff.sel_n;
  assign wds_n_s = s2_ff.write_or_data_strobe_n;
  assign rdd_n_s = s2_ff.rd_or_dir_n;

  // active-high qualifiers; separate mode: read strobe on rd pin
  logic wr_act, rd_act, act;
  always_comb begin
    if (mode_in == HPP_MODE_SEP) begin
      wr_act = !(sel_n_s | wds_n_s);
      rd_act = !(sel_n_s | rdd_n_s);
    end else begin
      // direction low means write, stable by host
      wr_act = !(sel_n_s | wds_n_s | rdd_n_s);
      rd_act = !(sel_n_s | wds_n_s) & rdd_n_s;
    end
    act = wr_act | rd_act;
  end

  // ----------------------------------------
  // handshake state machine
  // ----------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_WAIT, ST_BUSY, ST_LEAD, ST_DONE
  } hpp_state_t;

  hpp_state_t st_ff, nxt_st;
  logic [CNT_W-1:0] cnt_ff, nxt_cnt;
  logic is_rd_ff, nxt_is_rd;
  logic drv_ff, nxt_drv;
  logic [DATA_W-1:0] rd_ff, nxt_rd;
  hpp_req_t req_ff, nxt_req;
  logic req_v;

  always_comb begin
    nxt_st = st_ff;
    nxt_cnt = cnt_ff;
    nxt_is_rd = is_rd_ff;
    nxt_drv = drv_ff;
    nxt_rd = rd_ff;
    nxt_req = req_ff;
    req_v = 1'b0;
    unique case (st_ff)
      ST_IDLE: begin
        // bus stays off between accesses
        nxt_drv = 1'b0;
        if (act) begin
          nxt_st = ST_WAIT;
          nxt_is_rd = rd_act;
          nxt_cnt = CNT_ONE;
        end
      end
      ST_WAIT: begin
        // sync latency counts toward the settle time
        nxt_cnt = cnt_ff + CNT_ONE;
        if (!act) begin
          nxt_st = ST_IDLE;
        end else if (cnt_ff >= CNT_W'(SAMPLE_PERIODS)) begin
          nxt_req.write = !is_rd_ff;
          nxt_req.addr = s2_ff.addr;
          nxt_req.wdata = s2_ff.wdata;
          req_v = 1'b1;
          nxt_st = ST_BUSY;
        end
      end
      ST_BUSY: begin
        // done_in is only heeded here
        nxt_cnt = cnt_ff + CNT_ONE;
        if (is_rd_ff && cnt_ff >= CNT_W'(DRIVE_PERIODS)) begin
          nxt_drv = 1'b1;
        end
        if (done_in) begin
          nxt_rd = rdata_in;
          nxt_cnt = CNT_ZERO;
          nxt_st = ST_LEAD;
        end
      end
      ST_LEAD: begin
        // hold data a full period before ack edge
        nxt_drv = is_rd_ff;
        nxt_cnt = cnt_ff + CNT_ONE;
        if (cnt_ff >= CNT_W'(LEAD_PERIODS)) begin
          nxt_st = ST_DONE;
        end
      end
      ST_DONE: begin
        // ack level holds until the host lets go
        if (!act) begin
          nxt_drv = 1'b0;
          nxt_st = ST_IDLE;
        end
      end
      // a stray code after an upset falls back to idle
      default: nxt_st = ST_IDLE;
    endcase
    if (!act && st_ff != ST_IDLE && st_ff != ST_DONE) begin
      // host aborted; drop bus at once
      nxt_drv = 1'b0;
      nxt_st = ST_IDLE;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (rst_in) begin
      st_ff <= ST_IDLE;
      cnt_ff <= CNT_ZERO;
      is_rd_ff <= 1'b0;
      drv_ff <= 1'b0;
      rd_ff <= DATA_ZERO;
      req_ff <= '0;
    end else begin
      st_ff <= nxt_st;
      cnt_ff <= nxt_cnt;
      is_rd_ff <= nxt_is_rd;
      drv_ff <= nxt_drv;
      rd_ff <= nxt_rd;
      req_ff <= nxt_req;
    end
  end

  // ----------------------------------------
  // raw pin qualifier
  // ----------------------------------------
  // ack timing relies on a direct decode of the raw pins since the
  // synchronised path would exceed the few-ns limits
  logic raw_wr_act, raw_rd_act, raw_act;
  always_comb begin
    if (mode_in == HPP_MODE_SEP) begin
      raw_wr_act = !(pins_in.sel_n | pins_in.write_or_data_strobe_n);
      raw_rd_act = !(pins_in.sel_n | pins_in.rd_or_dir_n);
    end else begin
      // direction steers the transfer only, it never gates ack
      raw_wr_act = !(pins_in.sel_n | pins_in.write_or_data_strobe_n);
      raw_rd_act = 1'b0;
    end
    raw_act = raw_wr_act | raw_rd_act;
  end

  // ----------------------------------------
  // pin outputs
  // ----------------------------------------
  logic done_st;
  assign done_st = (st_ff == ST_DONE);

  always_comb begin
    // ack enable follows the raw pins; data enable is drv_ff from the sync path, gated by the raw pins
    ack_oe_out = raw_act;
    if (mode_in == HPP_MODE_SEP) begin
      ack_n_out = done_st;
    end else begin
      // back high as soon as the host lets go, so the line is
      // left inactive when its enable drops
      ack_n_out = !(done_st & raw_act);
    end
    data_oe_out = drv_ff & raw_act;
  end

  assign data_out = rd_ff;
  assign req_out = req_ff;
  assign req_valid_out = req_v;
endmodule : hpp_port
`default_nettype wire

// *** hpp_checker.sv ***
// checker for the host port handshake
`default_nettype none
module hpp_checker (
  input wire logic clk_sys_in,
  input wire logic rst_in,
  input wire hpp_pkg::hpp_mode_t mode_in,
  input wire hpp_pkg::hpp_pins_t pins_in,
  input wire logic ack_n_out,
  input wire logic ack_oe_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out,
  input wire logic req_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import hpp_pkg::*;
  logic sep, act;
  assign sep = mode_in == HPP_MODE_SEP;
  // raw qualifier, clean only while host keeps its edge rules
  assign act = !pins_in.sel_n & (!pins_in.write_or_data_strobe_n |
                                 sep & !pins_in.rd_or_dir_n);
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (rst_in);
  a_ack_drive: assert property (act |-> ack_oe_out)
    else $error("ack undriven");
  a_ack_float: assert property (!act |-> !ack_oe_out)
    else $error("ack driven");
  a_data_float: assert property (!act |-> !data_oe_out)
    else $error("data driven");
  a_drive_late: assert property (data_oe_out |->
    $past(act) && $past(act, 2) && $past(act, 3) &&
    (sep ^ pins_in.rd_or_dir_n)) else $error("early");
  a_ds_release: assert property (!sep && !act |-> ack_n_out)
    else $error("ack left low");
  a_sep_start: assert property (sep && $rose(act) |-> !ack_n_out)
    else $error("ack high");
  a_ds_start: assert property (!sep && $rose(act) |-> ack_n_out)
    else $error("ack low");
  a_sep_lead: assert property (sep && $rose(ack_n_out) && data_oe_out |->
    $past(data_oe_out) && $stable(data_out)) else $error("late data");
  a_ds_lead: assert property (!sep && $fell(ack_n_out) && data_oe_out |->
    $past(data_oe_out) && $stable(data_out)) else $error("late data");
  a_req_after: assert property (req_valid_out |->
    act && $past(act) && $past(act, 2)) else $error("early request");
endmodule : hpp_checker
`default_nettype wire

// *** hpp_host.sv ***
// host bus master model
`default_nettype none
module hpp_host (
  input wire logic clk_sys_in,
  input wire logic ack_n_out,
  input wire logic ack_oe_out,
  input wire logic [7:0] data_out,
  input wire logic data_oe_out,
  output hpp_pkg::hpp_pins_t pins_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import hpp_pkg::*;
  initial pins_out = '1;
  task automatic access(input logic ds, wr, input logic [7:0] a, d,
    input int lim, output logic [7:0] q, output logic ok);
    ok = 0;
    @(posedge clk_sys_in) #1;
    pins_out.rd_or_dir_n = ds ^ wr;
    pins_out.addr = a;
    pins_out.wdata = d;
    @(posedge clk_sys_in) #1;
    pins_out.sel_n = 0;
    pins_out.write_or_data_strobe_n = !ds & !wr;
    for (int i = 0; i < lim && !ok; i++) begin
      @(posedge clk_sys_in);
      ok = i > 5 && ack_oe_out && ack_n_out === !ds;
    end
    // an undriven data bus reads back as the inverse
    q = data_oe_out ? data_out : ~data_out;
    // bus no longer valid, so show the inverse
    #1 pins_out = {2'h3, pins_out.rd_or_dir_n, ~a, ~d};
    repeat (3) @(posedge clk_sys_in);
  endtask : access
endmodule : hpp_host
`default_nettype wire

// *** tb_host_parallel_port_handshake.sv ***
// bench for the host port handshake
`default_nettype none
module tb_host_parallel_port_handshake;
  timeunit 1ns;
  timeprecision 1ps;
  import hpp_pkg::*;
  logic clk_sys_in = 0, rst_in = 1, done_in = 0, ok;
  logic ack_n_out, ack_oe_out, data_oe_out, req_valid_out;
  logic [7:0] data_out, rdata_in = 8'h00, q;
  hpp_mode_t mode_in = HPP_MODE_SEP;
  hpp_pins_t pins_in;
  hpp_req_t req_out;
  int failures = 0, num_checks = 0, lat = 1;
  hpp_port hpp_port_inst (.clk_sys_in, .rst_in, .mode_in, .pins_in,
    .ack_n_out, .ack_oe_out, .data_out, .data_oe_out, .req_out,
    .req_valid_out, .done_in, .rdata_in);
  hpp_host hpp_host_inst (.clk_sys_in, .ack_n_out, .ack_oe_out,
    .data_out, .data_oe_out, .pins_out(pins_in));
  initial forever #5 clk_sys_in = ~clk_sys_in;
  // register side answers after lat cycles
  always @(posedge clk_sys_in) begin
    if (req_valid_out) begin
      repeat (lat) @(posedge clk_sys_in);
      #1 rdata_in = ~req_out.addr;
      done_in = 1;
      @(posedge clk_sys_in) #1 done_in = 0;
    end
  end
  task automatic chk(input logic [8:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t: %h not %h", $time, seen, exp);
    end
  endtask : chk
  task automatic conclude;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : conclude
  task automatic xfer(input logic ds, wr, input logic [7:0] a);
    @(posedge clk_sys_in) #1 mode_in = hpp_mode_t'(ds);
    hpp_host_inst.access(ds, wr, a, a ^ 8'hA5, 300, q, ok);
    chk(ok, 1'h1);
    chk({req_out.write, req_out.addr}, {wr, a});
    chk(wr ? req_out.wdata : q, wr ? a ^ 8'hA5 : {1'b0, ~a});
    if (!ok) conclude();
  endtask : xfer
  task automatic t_sep;
    xfer(1'h0, 1'h1, 8'h00);
    xfer(1'h0, 1'h0, 8'hFF);
    $display("t_sep done");
  endtask : t_sep
  task automatic t_ds;
    lat = 7;
    xfer(1'h1, 1'h0, 8'h00);
    xfer(1'h1, 1'h1, 8'hFF);
    xfer(1'h1, 1'h0, 8'h3C);
    $display("t_ds done");
  endtask : t_ds
  task automatic t_abort;
    for (int m = 0; m < 2; m++) begin
      @(posedge clk_sys_in) #1 mode_in = hpp_mode_t'(m[0]);
      hpp_host_inst.access(m[0], 1'h0, 8'h55, 8'h00, 2, q, ok);
      chk({ok, ack_oe_out, data_oe_out}, 9'h000);
      xfer(m[0], 1'h0, 8'h81);
    end
    $display("t_abort done");
  endtask : t_abort
  initial begin
    repeat (8) @(posedge clk_sys_in);
    #1 rst_in = 0;
    t_sep();
    t_ds();
    t_abort();
    conclude();
  end
endmodule : tb_host_parallel_port_handshake
bind hpp_port hpp_checker hpp_checker_inst (.clk_sys_in, .rst_in, .mode_in,
  .pins_in, .ack_n_out, .ack_oe_out, .data_out, .data_oe_out,
  .req_valid_out);
`default_nettype wire
